//--- rtl/msp_pkg.sv
// Shared constants and types of the memory select and protect control.
// Assumes one system clock of 200 MHz and a synchronous active-high reset.
package msp_pkg;

   // ==========================================================
   // Register space offsets (byte offsets in the register space)
   localparam logic [7:0] OFS_PAGE = 8'hE0;
   localparam logic [7:0] OFS_MAIN_PROT = 8'hC0;
   localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
   localparam logic [7:0] OFS_SPACE_MAP = 8'hC4;

   // ==========================================================
   // Space mapping fields, space mapping and page reset values
   localparam int VM_SRAM_CODE = 0;
   localparam int VM_BOOT_CODE = 1;
   localparam int VM_MAIN_CODE = 2;
   localparam int VM_BOOT_DATA = 3;
   localparam int VM_MAIN_DATA = 4;
   localparam int VM_PARALLEL_IO_MODE_ENABLE = 7;
   localparam logic [7:0] VM_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // Boot protect register field and sector counts
   localparam int BOOT_SECURITY_BIT = 7;
   localparam int MAIN_SECTORS = 8;
   localparam int BOOT_SECTORS = 4;

   // ==========================================================
   // Flash command words
   localparam logic [11:0] UNLOCK1_ADDR = 12'hAAA;
   localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
   localparam logic [11:0] UNLOCK2_ADDR = 12'h554;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] RESET_CMD_DATA = 8'hF0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int RECOVER_NS = 25000;
   localparam int RECOVER_CYC = RECOVER_NS / CLK_PERIOD_NS;
   localparam int TMR_W = 16;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      FS_READ,
      FS_UNLK1,
      FS_UNLK2,
      FS_RECOVER
   } msp_fsm_t;

   typedef enum logic [1:0] {
      OP_IDLE,
      OP_WORD_PGM,
      OP_BULK_ERASE,
      OP_SECTOR_ERASE
   } msp_op_t;

   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [7:0] data;
   } msp_flash_wr_t;

   typedef struct packed {
      logic [MAIN_SECTORS-1:0] main;
      logic [BOOT_SECTORS-1:0] boot;
      logic sram;
      logic io;
   } msp_sel_t;

   typedef struct packed {
      msp_fsm_t fsm;
      logic [TMR_W-1:0] tmr;
      logic [7:0] vm;
      logic [7:0] page;
      logic [7:0] rdata;
      logic abort;
      logic batt;
   } msp_state_t;

endpackage

//--- rtl/msp_sel_prio.sv
// Select priority and strobe gating of the memory select control.
// Assumes raw selects come from the address decode array, all combinational.
`timescale 1ns/100ps
module msp_sel_prio
   import msp_pkg::*;
(
   // Raw selects and strobes
   input wire msp_sel_t raw_i,
   input wire logic code_strobe_i,
   input wire logic data_strobe_i,
   input wire logic [7:0] vm_i,
   // Resolved enables
   output msp_sel_t en_o
);

   logic boot_ok;
   logic main_ok;
   logic sram_ok;

   // ==========================================================
   // Strobe gating per memory
   always_comb begin
      boot_ok = (code_strobe_i & vm_i[VM_BOOT_CODE]) | (data_strobe_i & vm_i[VM_BOOT_DATA]);
      main_ok = (code_strobe_i & vm_i[VM_MAIN_CODE]) | (data_strobe_i & vm_i[VM_MAIN_DATA]);
      sram_ok = data_strobe_i | (code_strobe_i & vm_i[VM_SRAM_CODE]);
   end

   // ==========================================================
   // Priority: I/O, then SRAM, then boot, then main
   always_comb begin
      en_o = '0;
      if (raw_i.io) begin
         en_o.io = 1'b1;
      end else if (raw_i.sram) begin
         en_o.sram = sram_ok;
      end else if (|raw_i.boot) begin
         en_o.boot = raw_i.boot & {BOOT_SECTORS{boot_ok}};
      end else begin
         en_o.main = raw_i.main & {MAIN_SECTORS{main_ok}};
      end
   end

endmodule

//--- rtl/msp_ctrl.sv
// Memory select, sector protect, flash reset and page register control.
// Assumes a program/erase engine reports its operation and error status,
// and that the microcontroller bus is synchronous to sys_clk_i.
//
// Behaviour
// - Each set main protect bit blocks writes to its main flash sector.
// - Boot protect low four bits block writes to the boot flash sectors.
// - Boot protect top bit reads the security lock; bits 6..4 read zero.
// - Reset command is one write, optionally after AA@AAA and 55@554.
// - Reset command returns read mode at once, or 25 us after an error.
// - Reset command is ignored during word program or bulk erase.
// - Reset command aborts sector erase, read mode within 25 us.
// - Reset pin aborts any operation; up to 25 us if one was running.
// - SRAM responds only while its decoder select is high.
// - When configured, battery indicator high while battery powers SRAM.
// - Boot sector select wins over an overlapping main sector select.
// - SRAM or I/O select wins over any overlapping flash select.
// - Space mapping bits 0..4 gate code and data strobes per memory.
// - Space mapping bit 7 enables parallel I/O mode; bits 6, 5 unused.
// - Space mapping loads its initial value at reset, writes act at once.
// - Eight-bit readable, writable page register feeds the decoder.
// - Page register sits at offset E0h of the register space.
// - Protection bits are readable but writes do not change them.
// - Program or erase to a protected sector is silently dropped.
`timescale 1ns/100ps
module msp_ctrl
   import msp_pkg::*;
#(
   parameter int RECOVER_CYCLES = RECOVER_CYC,
   parameter logic [7:0] VM_INIT = VM_RESET
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register space access
   input wire logic reg_sel_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Flash command writes and engine status
   input wire msp_flash_wr_t fl_cmd_i,
   input wire msp_op_t op_kind_i,
   input wire logic error_status_bit_i,
   input wire logic flash_reset_pin_i,
   output logic flash_read_mode_o,
   output logic flash_abort_o,
   // Protection
   input wire logic [MAIN_SECTORS-1:0] main_sector_protect_i,
   input wire logic [BOOT_SECTORS-1:0] boot_sector_protect_i,
   input wire logic security_lock_i,
   input wire logic pe_req_i,
   output logic pe_allow_o,
   // Address decode
   input wire msp_sel_t dec_i,
   input wire logic code_fetch_strobe_i,
   input wire logic data_strobe_i,
   output msp_sel_t en_o,
   output logic [7:0] page_outputs_o,
   output logic parallel_io_mode_enable_o,
   // Battery indicator
   input wire logic batt_cfg_i,
   input wire logic supply_below_batt_i,
   output logic battery_on_o
);

   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(RECOVER_CYCLES - 1);

   msp_state_t s_q;
   msp_state_t s_d;
   logic reg_wr_hit;
   logic reg_rd_hit;
   logic reset_cmd;
   logic op_busy;
   logic prot_hit;

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // ==========================================================
   // Select priority
   msp_sel_prio u_sel_prio (
      .raw_i(dec_i),
      .code_strobe_i(code_fetch_strobe_i),
      .data_strobe_i(data_strobe_i),
      .vm_i(s_q.vm),
      .en_o(en_o)
   );

   // ==========================================================
   // Decode of requests
   always_comb begin
      reg_wr_hit = reg_sel_i & reg_wr_i;
      reg_rd_hit = reg_sel_i & reg_rd_i;
      reset_cmd = fl_cmd_i.wr & (fl_cmd_i.data == RESET_CMD_DATA);
      op_busy = (op_kind_i != OP_IDLE);
      prot_hit = |(en_o.main & main_sector_protect_i) | |(en_o.boot & boot_sector_protect_i);
      pe_allow_o = pe_req_i & ~prot_hit & (|en_o.main | |en_o.boot);
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.abort = 1'b0;
      s_d.batt = batt_cfg_i & supply_below_batt_i;
      // Register writes; protect registers take no writes
      if (reg_wr_hit && reg_hit(reg_addr_i, OFS_PAGE)) begin
         s_d.page = reg_wdata_i;
      end
      if (reg_wr_hit && reg_hit(reg_addr_i, OFS_SPACE_MAP)) begin
         s_d.vm = reg_wdata_i;
      end
      // Register reads
      if (reg_rd_hit) begin
         s_d.rdata = 8'h00;
         if (reg_hit(reg_addr_i, OFS_PAGE)) begin
            s_d.rdata = s_q.page;
         end
         if (reg_hit(reg_addr_i, OFS_SPACE_MAP)) begin
            s_d.rdata = {s_q.vm[7], 2'b00, s_q.vm[4:0]};
         end
         if (reg_hit(reg_addr_i, OFS_MAIN_PROT)) begin
            s_d.rdata = main_sector_protect_i;
         end
         if (reg_hit(reg_addr_i, OFS_BOOT_PROT)) begin
            s_d.rdata = {security_lock_i, 3'b000, boot_sector_protect_i};
         end
      end
      // Flash command sequencing
      case (s_q.fsm)
         FS_READ: begin
            if (fl_cmd_i.wr && fl_cmd_i.addr == UNLOCK1_ADDR && fl_cmd_i.data == UNLOCK1_DATA) begin
               s_d.fsm = FS_UNLK1;
            end
         end
         FS_UNLK1: begin
            if (fl_cmd_i.wr) begin
               if (fl_cmd_i.addr == UNLOCK2_ADDR && fl_cmd_i.data == UNLOCK2_DATA) begin
                  s_d.fsm = FS_UNLK2;
               end else begin
                  s_d.fsm = FS_READ;
               end
            end
         end
         FS_UNLK2: begin
            if (fl_cmd_i.wr) begin
               s_d.fsm = FS_READ;
            end
         end
         FS_RECOVER: begin
            if (s_q.tmr == '0) begin
               s_d.fsm = FS_READ;
            end else begin
               s_d.tmr = s_q.tmr - 1'b1;
            end
         end
         default: begin
            s_d.fsm = FS_READ;
         end
      endcase
      // Reset command, taken in any unlock state
      if (reset_cmd && s_q.fsm != FS_RECOVER) begin
         if (error_status_bit_i) begin
            s_d.fsm = FS_RECOVER;
            s_d.tmr = TMR_LOAD;
         end else if (op_kind_i == OP_SECTOR_ERASE) begin
            s_d.fsm = FS_RECOVER;
            s_d.tmr = TMR_LOAD;
            s_d.abort = 1'b1;
         end else if (op_busy) begin
            // Ends any unlock sequence, no recovery
            s_d.fsm = FS_READ;
         end else begin
            s_d.fsm = FS_READ;
         end
      end
      // Reset pin overrides everything
      if (flash_reset_pin_i) begin
         if (op_busy) begin
            s_d.fsm = FS_RECOVER;
            s_d.tmr = TMR_LOAD;
            s_d.abort = 1'b1;
         end else if (s_q.fsm != FS_RECOVER) begin
            s_d.fsm = FS_READ;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q.fsm <= FS_READ;
         s_q.tmr <= '0;
         s_q.vm <= VM_INIT;
         s_q.page <= PAGE_RESET;
         s_q.rdata <= 8'h00;
         s_q.abort <= 1'b0;
         s_q.batt <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      reg_rdata_o = s_q.rdata;
      flash_read_mode_o = (s_q.fsm != FS_RECOVER);
      flash_abort_o = s_q.abort;
      page_outputs_o = s_q.page;
      parallel_io_mode_enable_o = s_q.vm[VM_PARALLEL_IO_MODE_ENABLE];
      battery_on_o = s_q.batt;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_main_prot_block: assert property (
      pe_req_i && |(en_o.main & main_sector_protect_i) |-> !pe_allow_o)
      else $error("write allowed to protected main sector");

   a_boot_prot_block: assert property (
      pe_req_i && |(en_o.boot & boot_sector_protect_i) |-> !pe_allow_o)
      else $error("write allowed to protected boot sector");

   a_security_read: assert property (
      reg_rd_hit && reg_addr_i == OFS_BOOT_PROT
      |=> reg_rdata_o == {$past(security_lock_i), 3'b000, $past(boot_sector_protect_i)})
      else $error("boot protect readback wrong");

   a_reset_now: assert property (
      reset_cmd && flash_read_mode_o && !error_status_bit_i && !op_busy
      && !flash_reset_pin_i |=> flash_read_mode_o && !flash_abort_o)
      else $error("reset command did not keep read mode");

   a_reset_error_wait: assert property (
      reset_cmd && flash_read_mode_o && error_status_bit_i && !flash_reset_pin_i
      |=> !flash_read_mode_o && s_q.tmr == TMR_LOAD)
      else $error("error reset did not start recovery");

   a_reset_ignored: assert property (
      reset_cmd && flash_read_mode_o && !error_status_bit_i && !flash_reset_pin_i
      && (op_kind_i == OP_WORD_PGM || op_kind_i == OP_BULK_ERASE)
      |=> flash_read_mode_o && !flash_abort_o)
      else $error("reset during program or bulk erase acted");

   a_sector_abort: assert property (
      reset_cmd && flash_read_mode_o && !error_status_bit_i && !flash_reset_pin_i
      && op_kind_i == OP_SECTOR_ERASE |=> flash_abort_o ##1 !flash_abort_o)
      else $error("sector erase not aborted");

   a_recover_end: assert property (
      !flash_read_mode_o && s_q.tmr == '0 && !flash_reset_pin_i |=> flash_read_mode_o)
      else $error("recovery did not end");

   a_pin_abort: assert property (
      flash_reset_pin_i && op_busy |=> flash_abort_o && !flash_read_mode_o)
      else $error("reset pin did not abort");

   a_pin_idle_read: assert property (
      flash_reset_pin_i && !op_busy && flash_read_mode_o |=> flash_read_mode_o && !flash_abort_o)
      else $error("idle reset pin left read mode");

   a_abort_pulse: assert property (
      flash_abort_o && !flash_reset_pin_i |=> !flash_abort_o)
      else $error("abort pulse longer than one cycle");

   a_sram_select: assert property (
      en_o.sram |-> dec_i.sram && !dec_i.io)
      else $error("sram enabled without select");

   a_battery_flag: assert property (
      batt_cfg_i && supply_below_batt_i |=> battery_on_o)
      else $error("battery indicator missing");

   a_boot_priority: assert property (
      |dec_i.boot |-> en_o.main == '0)
      else $error("main sector won over boot");

   a_sram_io_priority: assert property (
      dec_i.sram || dec_i.io |-> en_o.main == '0 && en_o.boot == '0)
      else $error("flash won over sram or io");

   a_code_gate: assert property (
      code_fetch_strobe_i && !data_strobe_i && |en_o.main |-> s_q.vm[VM_MAIN_CODE])
      else $error("code fetch reached main flash while gated");

   a_space_map_write: assert property (
      reg_wr_hit && reg_addr_i == OFS_SPACE_MAP
      |=> s_q.vm == $past(reg_wdata_i) && parallel_io_mode_enable_o == $past(reg_wdata_i[7]))
      else $error("space mapping write lost");

   a_page_write: assert property (
      reg_wr_hit && reg_addr_i == OFS_PAGE |=> page_outputs_o == $past(reg_wdata_i))
      else $error("page write lost");

endmodule

//--- testbench/msp_mcu_model.sv
// Microcontroller bus model: register accesses, flash commands, reset pin.
// Assumes the control samples every input on the rising edge of clk_i.
`timescale 1ns/100ps
module msp_mcu_model
   import msp_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Register space
   output logic reg_sel_o,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   // Flash commands and reset pin
   output msp_flash_wr_t fl_cmd_o,
   output logic reset_pin_o
);
   // ==========================================================
   // Bus cycles
   initial begin
      {reg_sel_o, reg_wr_o, reg_rd_o, reset_pin_o} = 4'h0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      fl_cmd_o = '0;
   end

   // Released address and data lines show the inverse of the last value; select and strobe lines go low
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_sel_o <= 1'b1;
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_sel_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_sel_o <= 1'b1;
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      reg_sel_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1 d = reg_rdata_i;
   endtask

   task automatic fl_wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      fl_cmd_o <= {1'b1, a, d};
      @(posedge clk_i);
      fl_cmd_o <= {1'b0, ~a, ~d};
   endtask

   task automatic fl_reset(input logic unlock);
      if (unlock) begin
         fl_wr(UNLOCK1_ADDR, UNLOCK1_DATA);
         fl_wr(UNLOCK2_ADDR, UNLOCK2_DATA);
      end
      fl_wr(UNLOCK1_ADDR, RESET_CMD_DATA);
   endtask

   // Pin held n cycles; with an operation busy, recovery counts from release
   task automatic pin_pulse(input int n);
      @(posedge clk_i);
      reset_pin_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      reset_pin_o <= 1'b0;
   endtask
endmodule

//--- testbench/tb_msp_ctrl.sv
// Self-checking bench of the memory select and protect control.
// Assumes msp_pkg and the bus model; recovery shortened to RC cycles.
`timescale 1ns/100ps
module tb_msp_ctrl
   import msp_pkg::*;
;
   // ==========================================================
   // Signals and instances
   localparam int RC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rsel, rwr, rrd, pin, err_bit, lock, pe_req, cs, ds, cfg, below;
   logic rdmode, abrt, pe_ok, pio, batt;
   logic [7:0] raddr, rwd, rrdata, page, mprot;
   logic [3:0] bprot;
   msp_flash_wr_t fl;
   msp_op_t op;
   msp_sel_t dec, en;
   int err_total = 0;
   int checked = 0;

   always #2.5 clk = ~clk;

   msp_ctrl #(.RECOVER_CYCLES(RC), .VM_INIT(8'h0C)) dut (
      .sys_clk_i(clk), .rst_i(rst), .reg_sel_i(rsel), .reg_addr_i(raddr),
      .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_wdata_i(rwd), .reg_rdata_o(rrdata),
      .fl_cmd_i(fl), .op_kind_i(op), .error_status_bit_i(err_bit),
      .flash_reset_pin_i(pin), .flash_read_mode_o(rdmode), .flash_abort_o(abrt),
      .main_sector_protect_i(mprot), .boot_sector_protect_i(bprot),
      .security_lock_i(lock), .pe_req_i(pe_req), .pe_allow_o(pe_ok),
      .dec_i(dec), .code_fetch_strobe_i(cs), .data_strobe_i(ds), .en_o(en),
      .page_outputs_o(page), .parallel_io_mode_enable_o(pio),
      .batt_cfg_i(cfg), .supply_below_batt_i(below), .battery_on_o(batt)
   );

   msp_mcu_model mcu (
      .clk_i(clk), .reg_sel_o(rsel), .reg_addr_o(raddr), .reg_wr_o(rwr),
      .reg_rd_o(rrd), .reg_wdata_o(rwd), .reg_rdata_i(rrdata), .fl_cmd_o(fl),
      .reset_pin_o(pin)
   );

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Raw selects go in on the edge that makes the map live
   task automatic dcase(input logic [7:0] vm, input logic [13:0] raw,
                        input logic [2:0] csp, input logic [13:0] ex, input logic pex);
      mcu.reg_wr(OFS_SPACE_MAP, vm);
      dec <= raw;
      {cs, ds, pe_req} <= csp;
      #1 chk(16'(en), 16'(ex));
      chk(16'(pe_ok), 16'(pex));
   endtask

   // Entered just after the edge that starts recovery
   task automatic recov(input logic ab);
      #1 chk(16'(abrt), 16'(ab));
      chk(16'(rdmode), 16'h0000);
      repeat (RC - 1) @(posedge clk);
      #1 chk(16'(rdmode), 16'h0000);
      chk(16'(abrt), 16'h0000);
      @(posedge clk);
      #1 chk(16'(rdmode), 16'h0001);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] d;
      mcu.reg_rd(OFS_SPACE_MAP, d);
      chk(16'(d), 16'h000C);
      mcu.reg_wr(OFS_PAGE, 8'h5A);
      #1 chk(16'(page), 16'h005A);
      mcu.reg_rd(OFS_PAGE, d);
      chk(16'(d), 16'h005A);
      mcu.reg_wr(OFS_SPACE_MAP, 8'hFF);
      #1 chk(16'(pio), 16'h0001);
      mcu.reg_rd(OFS_SPACE_MAP, d);
      chk(16'(d), 16'h009F);
      mcu.reg_wr(OFS_SPACE_MAP, 8'h7F);
      #1 chk(16'(pio), 16'h0000);
      mcu.reg_wr(OFS_MAIN_PROT, 8'h00);
      mcu.reg_wr(OFS_BOOT_PROT, 8'h00);
      mcu.reg_rd(OFS_MAIN_PROT, d);
      chk(16'(d), 16'(mprot));
      mcu.reg_rd(OFS_BOOT_PROT, d);
      chk(16'(d), 16'({lock, 3'h0, bprot}));
      @(posedge clk);
      lock <= 1'b0;
      mcu.reg_rd(OFS_BOOT_PROT, d);
      chk(16'(d), 16'h0006);
      mcu.reg_rd(8'h3D, d);
      chk(16'(d), 16'h0000);
   endtask

   // Same-level selects never overlap here
   task automatic t_decode();
      dcase(8'h1F, 14'h0044, 3'h2, 14'h0004, 1'b0);
      dcase(8'h1F, 14'h0046, 3'h2, 14'h0002, 1'b0);
      dcase(8'h1F, 14'h0041, 3'h2, 14'h0001, 1'b0);
      dcase(8'h01, 14'h0002, 3'h4, 14'h0002, 1'b0);
      dcase(8'h00, 14'h0002, 3'h4, 14'h0000, 1'b0);
      dcase(8'h1F, 14'h0002, 3'h0, 14'h0000, 1'b0);
      dcase(8'h02, 14'h0004, 3'h4, 14'h0004, 1'b0);
      dcase(8'h02, 14'h0004, 3'h2, 14'h0000, 1'b0);
      dcase(8'h0C, 14'h0004, 3'h2, 14'h0004, 1'b0);
      dcase(8'h0C, 14'h0040, 3'h4, 14'h0040, 1'b0);
      dcase(8'h0C, 14'h0040, 3'h2, 14'h0000, 1'b0);
      dcase(8'h14, 14'h0040, 3'h2, 14'h0040, 1'b0);
      dcase(8'h14, 14'h0100, 3'h3, 14'h0100, 1'b0);
      dcase(8'h14, 14'h0080, 3'h3, 14'h0080, 1'b1);
      dcase(8'h0C, 14'h0008, 3'h3, 14'h0008, 1'b0);
      dcase(8'h0C, 14'h0004, 3'h3, 14'h0004, 1'b1);
   endtask

   task automatic t_flash();
      @(posedge clk);
      op <= OP_IDLE;
      mcu.fl_reset(1'b0);
      #1 chk(16'({abrt, rdmode}), 16'h0001);
      for (int k = 1; k < 3; k++) begin
         @(posedge clk);
         op <= msp_op_t'(k);
         mcu.fl_reset(1'b1);
         #1 chk(16'({abrt, rdmode}), 16'h0001);
      end
      @(posedge clk);
      op <= OP_SECTOR_ERASE;
      mcu.fl_reset(1'b1);
      recov(1'b1);
      @(posedge clk);
      op <= OP_IDLE;
      err_bit <= 1'b1;
      mcu.fl_reset(1'b0);
      recov(1'b0);
      @(posedge clk);
      err_bit <= 1'b0;
      op <= OP_SECTOR_ERASE;
      mcu.pin_pulse(RC);
      recov(1'b1);
      @(posedge clk);
      op <= OP_IDLE;
      mcu.pin_pulse(2);
      @(posedge clk);
      #1 chk(16'({abrt, rdmode}), 16'h0001);
   endtask

   task automatic t_batt();
      @(posedge clk);
      cfg <= 1'b1;
      below <= 1'b1;
      @(posedge clk);
      #1 chk(16'(batt), 16'h0001);
      @(posedge clk);
      cfg <= 1'b0;
      @(posedge clk);
      #1 chk(16'(batt), 16'h0000);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      {err_bit, pe_req, cs, ds, cfg, below} = 6'h00;
      lock = 1'b1;
      mprot = 8'hA5;
      bprot = 4'h6;
      op = OP_IDLE;
      dec = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_decode();
      t_flash();
      t_batt();
      tally_and_finish();
   end

   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
endmodule
